// file: design/sram_defs.svh
/*
 * Constants of the pipelined burst SRAM access logic: widths, counts, codes.
 * Assumes inclusion by bare name from every design file that needs them.
 */
// Summary of operation
// - synchronous inputs taken at the clock rise; read data leaves through output registers.
// - a strobe with chip selected and both write enables high begins a read.
// - read address registered at start; data driven after next rise if output enabled.
// - first data cycle after leaving deselect stays high impedance regardless of enable.
// - a strobe with chips not selected deselects and floats outputs at once.
// - processor strobe start loads the address, ignoring write controls and advance.
// - processor-strobe write takes two clocks; second rise controls and data decide.
// - with global write high, only low byte selects are written under byte enable.
// - low global write writes every byte of the word.
// - data pins float whenever a write cycle is seen, whatever the output enable.
// - controller strobe, processor strobe high, selected, write requested starts a write.
// - controller-strobe write completes in one clock; advance ignored that cycle.
// - every address strobe loads the two low address bits into the burst counter.
// - low advance steps the burst counter, for reads and writes; otherwise it holds.
// - interleaved order gives start bits XOR access number.
// - linear order gives start bits plus access number, modulo four.
// - burst order follows the sampled order select level.
// - order select is static; low means linear, high means interleaved.
// - sleep input enters a data-keeping sleep state; entry and exit take two clocks.
// - accesses pending when sleep is entered are treated as invalid; the code keeps queued writes and stores them after wake-up.
`ifndef SRAM_DEFS_SVH
`define SRAM_DEFS_SVH
`define SRAM_ADDR_W      19
`define SRAM_LANES       4
`define SRAM_BYTE_W      8
`define SRAM_LANE_W      9
`define SRAM_BURST_W     2
`define SRAM_FIFO_DEPTH  8
`define SRAM_CLK_NS      20
`define SRAM_ZZ_CYC      2
`define SRAM_ORDER_LIN   1'b0
`endif

// file: design/sram_pkg.sv
/*
 * Types shared by the SRAM access logic.
 * Assumes sram_defs.svh is on the include path.
 */
`include "sram_defs.svh"
package sram_pkg;
    typedef struct packed {
        logic [`SRAM_ADDR_W-1:0]             addr;
        logic [`SRAM_LANES-1:0]              mask;
        logic [`SRAM_LANES*`SRAM_LANE_W-1:0] data;
    } wr_cmd_t;

    typedef enum logic [1:0] {
        SLP_AWAKE,
        SLP_ENTER,
        SLP_ASLEEP,
        SLP_LEAVE
    } sleep_state_t;
endpackage

// file: design/sram_fifo.sv
/*
 * Small synchronous FIFO with valid and ready on both sides.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module sram_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    input  wire logic         clk_i,       // clock
    input  wire logic         rst_i,       // sync reset
    input  wire logic         in_valid_i,  // push request
    output logic              in_ready_o,  // room for a word
    input  wire logic [W-1:0] in_data_i,   // pushed word
    output logic              out_valid_o, // word available
    input  wire logic         out_ready_i, // pop request
    output logic [W-1:0]      out_data_o   // head word
);
    localparam int PW = $clog2(DEPTH);
    logic [W-1:0]  mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0]   count;
    wire           push = in_valid_i & in_ready_o;
    wire           pop  = out_valid_o & out_ready_i;

    assign in_ready_o  = (count != (PW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rd_ptr];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule // sram_fifo
`default_nettype wire

// file: design/sram_array.sv
/*
 * Storage array with a lane-masked write port and a registered read port.
 * Assumes one clock; contents are not cleared by reset.
 */
`timescale 1ns/1ps
`default_nettype none
module sram_array #(
    parameter int AW = 19,
    parameter int NB = 4,
    parameter int LW = 9
) (
    input  wire logic               clk_i,      // clock
    input  wire logic               rst_i,      // sync reset, read register only
    input  wire logic               wr_en_i,    // write strobe
    input  wire logic [AW-1:0]      wr_addr_i,  // write address
    input  wire logic [NB-1:0]      wr_mask_i,  // lanes to write
    input  wire logic [NB*LW-1:0]   wr_data_i,  // write word
    input  wire logic [AW-1:0]      rd_addr_i,  // read address
    output logic      [NB*LW-1:0]   rd_data_o   // registered read word
);
    logic [NB*LW-1:0] lane_rd;

    // each lane owns its array, so a masked write has a single writer per lane
    for (genvar k = 0; k < NB; k++) begin : g_lane
        logic [LW-1:0] mem [2**AW];

        always_ff @(posedge clk_i) begin
            if (wr_en_i && wr_mask_i[k]) begin
                mem[wr_addr_i] <= wr_data_i[k*LW +: LW];
            end
        end

        assign lane_rd[k*LW +: LW] = mem[rd_addr_i];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_data_o <= '0;
        end else begin
            rd_data_o <= lane_rd;
        end
    end
endmodule // sram_array
`default_nettype wire

// file: design/pipelined_burst_sram_access.sv
/*
 * Access logic of a pipelined burst SRAM with common data I/O: strobe
 * decode, burst counter, write queue, registered read path, sleep control.
 * Assumes the data pin wire is resolved outside from dq_oe_o.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sram_defs.svh"
module pipelined_burst_sram_access #(
    parameter int FIFO_DEPTH = `SRAM_FIFO_DEPTH
) (
    input  wire logic                        core_clk_i,                  // clock
    input  wire logic                        sys_rst_i,                   // sync reset
    input  wire logic [`SRAM_ADDR_W-1:0]     addr_i,                      // address pins
    input  wire logic                        chip_sel_first_n_i,          // select 1, low
    input  wire logic                        chip_sel_second_i,           // select 2, high
    input  wire logic                        chip_sel_third_n_i,          // select 3, low
    input  wire logic                        processor_addr_strobe_n_i,   // cpu strobe
    input  wire logic                        controller_addr_strobe_n_i,  // ctrl strobe
    input  wire logic                        burst_advance_n_i,           // advance, low
    input  wire logic                        global_write_n_i,            // all-byte write
    input  wire logic                        byte_write_enable_n_i,       // byte write enable
    input  wire logic [`SRAM_LANES-1:0]      byte_select_n_i,             // byte selects
    input  wire logic                        output_enable_n_i,           // async enable
    input  wire logic                        burst_order_i,               // 1 interleaved
    input  wire logic                        sleep_request_i,             // async sleep
    input  wire logic [`SRAM_LANES*8-1:0]    dq_i,                        // data pins in
    input  wire logic [`SRAM_LANES-1:0]      parity_io_i,                 // parity pins in
    output logic      [`SRAM_LANES*8-1:0]    dq_o,                        // data pins out
    output logic      [`SRAM_LANES-1:0]      parity_io_o,                 // parity pins out
    output logic                             dq_oe_o,                     // pin drive enable
    output logic                             write_ready_o,               // queue has room
    output logic                             write_drop_o,                // write lost
    output logic                             asleep_o,                    // in sleep
    output logic                             selected_o                   // device selected
);
    localparam int AW = `SRAM_ADDR_W;
    localparam int NB = `SRAM_LANES;
    localparam int LW = `SRAM_LANE_W;
    localparam int BW = `SRAM_BURST_W;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] async_meta;
    logic [2:0] async_sync;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            async_meta <= 3'h1;
            async_sync <= 3'h1;
        end else begin
            async_meta <= {burst_order_i, sleep_request_i, output_enable_n_i};
            async_sync <= async_meta;
        end
    end

    wire oe_n_s  = async_sync[0];
    wire zz_s    = async_sync[1];
    wire order_s = async_sync[2];

    // ------------------------------------------------------------
    // sleep control
    // ------------------------------------------------------------
    sram_pkg::sleep_state_t slp_state;
    sram_pkg::sleep_state_t next_slp_state;
    logic [1:0]             slp_cnt;
    wire                    slp_done = (slp_cnt == 2'(`SRAM_ZZ_CYC - 1));

    always_comb begin
        next_slp_state = slp_state;
        case (slp_state)
            sram_pkg::SLP_AWAKE: begin
                if (zz_s) begin
                    next_slp_state = sram_pkg::SLP_ENTER;
                end
            end
            sram_pkg::SLP_ENTER: begin
                if (!zz_s) begin
                    next_slp_state = sram_pkg::SLP_LEAVE;
                end else if (slp_done) begin
                    next_slp_state = sram_pkg::SLP_ASLEEP;
                end
            end
            sram_pkg::SLP_ASLEEP: begin
                if (!zz_s) begin
                    next_slp_state = sram_pkg::SLP_LEAVE;
                end
            end
            sram_pkg::SLP_LEAVE: begin
                if (zz_s) begin
                    next_slp_state = sram_pkg::SLP_ENTER;
                end else if (slp_done) begin
                    next_slp_state = sram_pkg::SLP_AWAKE;
                end
            end
            default: begin
                next_slp_state = sram_pkg::SLP_AWAKE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            slp_state <= sram_pkg::SLP_AWAKE;
            slp_cnt   <= 2'h1;
        end else begin
            slp_state <= next_slp_state;
            slp_cnt   <= (next_slp_state != slp_state) ? 2'h1 : slp_cnt + 2'h1;
        end
    end

    // accesses are only taken while fully awake
    wire awake = (slp_state == sram_pkg::SLP_AWAKE);

    // ------------------------------------------------------------
    // strobe and select decode
    // ------------------------------------------------------------
    logic          active;
    logic [AW-1:0] addr_reg;
    logic [BW-1:0] burst_base;
    logic [BW-1:0] burst_num;

    wire sel    = !chip_sel_first_n_i & chip_sel_second_i & !chip_sel_third_n_i;
    wire p_act  = !processor_addr_strobe_n_i & !chip_sel_first_n_i;
    wire c_act  = !controller_addr_strobe_n_i & !p_act;
    wire strobe = awake & (p_act | c_act);
    wire wr_req = !global_write_n_i | (!byte_write_enable_n_i & ~&byte_select_n_i);
    wire desel  = strobe & !sel;
    wire p_start = strobe & sel & p_act;
    wire c_read  = strobe & sel & c_act & !wr_req;
    wire c_write = strobe & sel & c_act & wr_req;
    wire cont    = awake & active & !strobe;
    wire cont_wr = cont & wr_req;
    wire cont_rd = cont & !wr_req;
    wire advance = cont & !burst_advance_n_i;
    wire begin_rd = p_start | c_read;
    wire rd_take  = begin_rd | cont_rd;
    wire wr_take  = c_write | cont_wr;

    // ------------------------------------------------------------
    // burst counter
    // ------------------------------------------------------------
    wire [BW-1:0] next_burst_num = advance ? burst_num + 2'h1 : burst_num;
    wire          interleaved    = (order_s != `SRAM_ORDER_LIN);
    wire [BW-1:0] ilv_lo = burst_base ^ next_burst_num;
    wire [BW-1:0] lin_lo = burst_base + next_burst_num;
    wire [BW-1:0] acc_lo = interleaved ? ilv_lo : lin_lo;
    wire [AW-1:0] acc_addr = strobe ? addr_i : {addr_reg[AW-1:BW], acc_lo};

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            active     <= 1'b0;
            addr_reg   <= '0;
            burst_base <= '0;
            burst_num  <= '0;
        end else if (!awake) begin
            active <= 1'b0;
        end else if (strobe) begin
            active     <= sel;
            addr_reg   <= addr_i;
            burst_base <= addr_i[BW-1:0];
            burst_num  <= '0;
        end else begin
            burst_num <= next_burst_num;
        end
    end

    // ------------------------------------------------------------
    // write queue
    // ------------------------------------------------------------
    sram_pkg::wr_cmd_t wr_cmd;
    sram_pkg::wr_cmd_t drain_cmd;
    logic [NB*LW-1:0]  in_word;
    logic [NB*LW-1:0]  rd_word;
    logic              fifo_ready;
    logic              drain_valid;

    for (genvar k = 0; k < NB; k++) begin : g_lane
        assign in_word[k*LW +: LW]  = {parity_io_i[k], dq_i[k*8 +: 8]};
        assign dq_o[k*8 +: 8]       = rd_word[k*LW +: 8];
        assign parity_io_o[k]       = rd_word[k*LW + 8];
    end

    wire [NB-1:0] wr_mask = !global_write_n_i ? {NB{1'b1}}
                          : (!byte_write_enable_n_i ? ~byte_select_n_i : '0);
    wire          fifo_push = wr_take & fifo_ready;

    assign wr_cmd.addr   = acc_addr;
    assign wr_cmd.mask   = wr_mask;
    assign wr_cmd.data   = in_word;
    assign write_ready_o = fifo_ready;
    assign write_drop_o  = wr_take & !fifo_ready;

    // draining stalls during sleep so queued words wait for the wake-up
    sram_fifo #(
        .W     ($bits(sram_pkg::wr_cmd_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .clk_i       (core_clk_i),
        .rst_i       (sys_rst_i),
        .in_valid_i  (fifo_push),
        .in_ready_o  (fifo_ready),
        .in_data_i   (wr_cmd),
        .out_valid_o (drain_valid),
        .out_ready_i (awake),
        .out_data_o  (drain_cmd)
    );

    // ------------------------------------------------------------
    // array and read pipeline
    // ------------------------------------------------------------
    logic [AW-1:0] rd_addr;
    logic          rd_acc;
    logic          rd_valid;
    logic          first_acc;
    logic          first_mask;
    logic          wr_seen;

    sram_array #(
        .AW (AW),
        .NB (NB),
        .LW (LW)
    ) u_array (
        .clk_i     (core_clk_i),
        .rst_i     (sys_rst_i),
        .wr_en_i   (drain_valid & awake),
        .wr_addr_i (drain_cmd.addr),
        .wr_mask_i (drain_cmd.mask),
        .wr_data_i (drain_cmd.data),
        .rd_addr_i (rd_addr),
        .rd_data_o (rd_word)
    );

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            rd_addr    <= '0;
            rd_acc     <= 1'b0;
            rd_valid   <= 1'b0;
            first_acc  <= 1'b0;
            first_mask <= 1'b0;
            wr_seen    <= 1'b0;
        end else begin
            if (rd_take) begin
                rd_addr <= acc_addr;
            end
            rd_acc     <= rd_take;
            rd_valid   <= rd_acc & awake & !desel & !wr_take;
            first_acc  <= begin_rd & !active;
            first_mask <= first_acc;
            wr_seen    <= wr_take;
        end
    end

    assign dq_oe_o    = rd_valid & !first_mask & !wr_seen & !oe_n_s;
    assign asleep_o   = (slp_state == sram_pkg::SLP_ASLEEP);
    assign selected_o = active;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_DESEL_FLOAT: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        desel |=> !dq_oe_o)
        else $error("outputs driven after deselect");

    AST_WRITE_FLOAT: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        wr_take |=> !dq_oe_o)
        else $error("outputs driven in write cycle");

    AST_FIRST_MASK: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (begin_rd && !active) |=> ##1 !dq_oe_o)
        else $error("first data cycle after deselect driven");

    AST_READ_DRIVE: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (cont_rd && active && !first_acc ##1 awake && !desel && !wr_take && !oe_n_s
         && !first_acc) |=> dq_oe_o == !oe_n_s)
        else $error("read data not driven");

    AST_LOAD_BURST: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        strobe |=> (burst_num == 2'h0) && (burst_base == $past(addr_i[1:0])))
        else $error("burst counter not loaded");

    AST_STEP_BURST: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (cont && !burst_advance_n_i) |=> burst_num == $past(burst_num) + 2'h1)
        else $error("burst counter did not step");

    AST_HOLD_BURST: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (awake && !strobe && burst_advance_n_i) |=> $stable(burst_num))
        else $error("burst counter moved without advance");

    AST_PSTART_NOWR: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        p_start |-> !fifo_push && (burst_num == next_burst_num))
        else $error("processor strobe start wrote or advanced");

    AST_CWR_ONE: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (c_write && fifo_ready) |-> fifo_push && (wr_cmd.addr == addr_i))
        else $error("controller write not taken at once");

    AST_GLOBAL_ALL: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (fifo_push && !global_write_n_i) |-> wr_cmd.mask == {NB{1'b1}})
        else $error("global write missed a byte");

    AST_BYTE_ONLY: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (fifo_push && global_write_n_i) |-> wr_cmd.mask == ~byte_select_n_i)
        else $error("byte write mask wrong");

    AST_SLEEP_ENTER: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (awake && zz_s ##1 zz_s) |=> asleep_o)
        else $error("sleep not entered in two clocks");

    AST_SLEEP_QUIET: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        !awake |-> !fifo_push && !rd_take ##1 !rd_valid)
        else $error("access taken while not awake");

    AST_READ_START: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (strobe && sel && global_write_n_i && byte_write_enable_n_i)
        |=> rd_acc && (rd_addr == $past(addr_i)))
        else $error("read not started");

    AST_CWR_START: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (awake && sel && !controller_addr_strobe_n_i && processor_addr_strobe_n_i && wr_req)
        |-> wr_take && !rd_take)
        else $error("controller write not started");

    AST_BOTH_STROBE: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (awake && sel && !processor_addr_strobe_n_i && !controller_addr_strobe_n_i)
        |-> begin_rd && !wr_take)
        else $error("controller strobe honoured beside processor strobe");

    AST_CS1_IGNORE: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (chip_sel_first_n_i && controller_addr_strobe_n_i) |-> !strobe)
        else $error("processor strobe taken with first select high");

    AST_DESEL_CLEAR: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (strobe && (chip_sel_first_n_i || !chip_sel_second_i || chip_sel_third_n_i))
        |=> !selected_o)
        else $error("selected with wrong chip select levels");

    AST_SLEEP_LEAVE: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (asleep_o && !zz_s ##1 !zz_s) |=> awake)
        else $error("sleep not left in two clocks");

    AST_SLEEP_DROP: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        !awake |=> !selected_o)
        else $error("selection kept across sleep");
endmodule // pipelined_burst_sram_access
`default_nettype wire

// file: verification/bus_partner_model.sv
/*
 * Far-side controller model: resolves the shared data and parity wire.
 * Assumes the bench hands it the word to drive and the output enable level.
 */
`timescale 1ns/1ps
`default_nettype none
module bus_partner_model (
    input  wire logic        clk_i,    // clock
    input  wire logic        oe_n_i,   // output enable pin level
    input  wire logic [35:0] data_i,   // word the controller drives
    input  wire logic        dev_oe_i, // device drives the wire
    input  wire logic [35:0] dev_i,    // device word
    output logic      [35:0] wire_o    // resolved wire
);
    logic [35:0] last = 36'h0;
    // controller drives only while output enable is high; a released wire toggles
    assign wire_o = dev_oe_i ? dev_i : (oe_n_i ? data_i : ~last);
    always @(posedge clk_i) last <= wire_o;
endmodule // bus_partner_model
`default_nettype wire

// file: verification/pipelined_burst_sram_access_bench.sv
/*
 * Self-checking bench: writes, byte writes, bursts in both orders, sleep.
 * Assumes the design files and bus_partner_model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module pipelined_burst_sram_access_bench;
    logic        core_clk_i = 1'b0, sys_rst_i = 1'b1, oe_n = 1'b1, ord = 1'b0, zz = 1'b0;
    logic [5:0]  k = 6'b101111; // {first select n, cpu n, ctrl n, advance n, global n, byte n}
    logic [3:0]  bs = 4'hF, par_o;
    logic [18:0] addr = 19'h0;
    logic [16:0] blk;
    logic [35:0] wdat = 36'h0, wire_w, d, mem [4], exp_q [$];
    logic [31:0] dq_o, v, seed = 32'hEE8E;
    logic        dq_oe, wr_rdy, drop, asleep, sel;
    logic        cs2 = 1'b1, cs3_n = 1'b0;
    int          num_errors = 0, checks_done = 0, cycles = 0;
    always #10 core_clk_i = ~core_clk_i;
    pipelined_burst_sram_access #(.FIFO_DEPTH(8)) dut_u (.core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i), .addr_i(addr), .chip_sel_first_n_i(k[5]),
        .chip_sel_second_i(cs2), .chip_sel_third_n_i(cs3_n),
        .processor_addr_strobe_n_i(k[4]), .controller_addr_strobe_n_i(k[3]),
        .burst_advance_n_i(k[2]), .global_write_n_i(k[1]), .byte_write_enable_n_i(k[0]),
        .byte_select_n_i(bs), .output_enable_n_i(oe_n), .burst_order_i(ord),
        .sleep_request_i(zz), .dq_i(wire_w[31:0]), .parity_io_i(wire_w[35:32]),
        .dq_o(dq_o), .parity_io_o(par_o), .dq_oe_o(dq_oe), .write_ready_o(wr_rdy),
        .write_drop_o(drop), .asleep_o(asleep), .selected_o(sel));
    bus_partner_model partner_u (.clk_i(core_clk_i), .oe_n_i(oe_n), .data_i(wdat),
        .dev_oe_i(dq_oe), .dev_i({par_o, dq_o}), .wire_o(wire_w));
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task stop_test;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input logic [35:0] e, input logic [35:0] s);
        checks_done++;
        if (e !== s) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task drv(input logic [5:0] kk, input logic [3:0] b, input logic [18:0] a,
             input logic [35:0] dd);
        @(posedge core_clk_i);
        k <= kk;
        bs <= b;
        addr <= a;
        wdat <= dd;
    endtask
    task idle(input int n);
        // deselect through the controller strobe; the low processor strobe is ignored
        repeat (n) drv(6'b100111, 4'hF, 19'h0, 36'h0);
    endtask
    // the first beat is masked after deselect, so only beats 1 to 3 are noted
    task burst(input logic [1:0] s, input logic [5:0] k0);
        logic [1:0] lo;
        drv(k0, 4'hF, {blk, s}, 36'h0);
        for (int n = 1; n < 4; n++) begin
            lo = ord ? s ^ n[1:0] : s + n[1:0];
            exp_q.push_back(mem[lo]);
            drv(6'b101011, 4'hF, {blk, s}, 36'h0);
        end
        drv(6'b011111, 4'hF, {blk, s}, 36'h0);
        idle(3);
    endtask
    // ----------------------------------------------------------------
    // watcher and timeout
    // ----------------------------------------------------------------
    always @(negedge core_clk_i) begin
        if (dq_oe === 1'b1)
            chk("read", exp_q.size() ? exp_q.pop_front() : ~{par_o, dq_o}, {par_o, dq_o});
        if (drop !== 1'b0)
            chk("drop", 36'h0, drop);
    end
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            stop_test();
        end
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (16) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        chk("idle", 36'h4, {wr_rdy, sel, dq_oe});
        v = rnd();
        blk = v[16:0];
        for (int w = 0; w < 4; w++) begin
            v = rnd();
            mem[w] = {v[3:0], rnd()};
            if (w == 0)
                drv(6'b001101, 4'h0, {blk, 2'h0}, ~mem[w]);
            drv(w == 0 ? 6'b011101 : 6'b010101, 4'hF, {blk, w[1:0]}, mem[w]);
        end
        v = rnd();
        d = {v[3:0], rnd()};
        drv(6'b010110, v[7:4], {blk, 2'h2}, d);
        for (int b = 0; b < 4; b++) begin
            if (!v[4+b]) begin
                mem[2][8*b+:8] = d[8*b+:8];
                mem[2][32+b] = d[32+b];
            end
        end
        idle(1);
        oe_n <= 1'b0;
        idle(3);
        burst(2'h3, 6'b001111);
        for (int c = 0; c < 2; c++) begin
            {cs2, cs3_n} <= c ? 2'b11 : 2'b00;
            drv(6'b001111, 4'hF, {blk, 2'h0}, 36'h0);
            repeat (2) drv(6'b011011, 4'hF, {blk, 2'h0}, 36'h0);
            chk("unselected", 36'h0, sel);
        end
        {cs2, cs3_n} <= 2'b10;
        ord <= 1'b1;
        idle(3);
        burst(2'h1, 6'b000101);
        zz <= 1'b1;
        for (int i = 0; i < 8 && asleep !== 1'b1; i++) @(posedge core_clk_i);
        chk("asleep", 36'h1, asleep);
        ord <= 1'b0;
        k <= 6'b111111;
        zz <= 1'b0;
        for (int i = 0; i < 8 && asleep !== 1'b0; i++) @(posedge core_clk_i);
        chk("awake", 36'h0, asleep);
        repeat (3) drv(6'b111111, 4'hF, 19'h0, 36'h0);
        burst(2'h3, 6'b001111);
        idle(4);
        chk("unread", 36'h0, exp_q.size());
        stop_test();
    end
endmodule // pipelined_burst_sram_access_bench
`default_nettype wire
